// ===== design/tcpu_pkg.sv
// Shared constants for the triple countdown timer block
package tcpu_pkg;
  localparam int COUNT_WIDTH = 32;
  localparam int PRESCALE_WIDTH = 16;
  localparam int NUM_TIMERS = 3;
  localparam int NUM_SOURCES = 3;
  localparam logic [31:0] COUNT_RESET = 32'hffffffff;
  localparam logic [15:0] PRESCALE_RESET = 16'h0000;
  localparam logic [31:0] COUNT_ZERO = 32'h00000000;
  localparam logic [31:0] COUNT_ONE = 32'h00000001;
  localparam logic [15:0] PRESCALE_ZERO = 16'h0000;
  localparam logic [15:0] PRESCALE_ONE = 16'h0001;
  // Timer 2 count clock selection codes
  localparam logic [1:0] SEL_SYSTEM_CLOCK = 2'h0;
  localparam logic [1:0] SEL_OSC_ONE = 2'h1;
  localparam logic [1:0] SEL_OSC_TWO = 2'h2;
  localparam logic [1:0] SEL_EXTERNAL = 2'h3;
  // Indices of the synchronised clock sources
  localparam int SRC_OSC_ONE = 0;
  localparam int SRC_OSC_TWO = 1;
  localparam int SRC_EXTERNAL = 2;
  localparam int TIMER_PIE = 0;
  localparam int TIMER_LINE13 = 1;
  localparam int TIMER_LINE14 = 2;
endpackage : tcpu_pkg

// ===== design/tcpu_timer_unit.sv
// One 32-bit countdown timer with 16-bit prescaler and auto reload
`timescale 1ns/1ps
`default_nettype none
module tcpu_timer_unit (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Count enable and settings
  input  wire logic        tick,
  input  wire logic [31:0] period,
  input  wire logic [15:0] prescale,
  // State and zero event
  output var  logic [31:0] count_reg,
  output var  logic        zero_reg
);
  logic [31:0] count_next;
  logic [15:0] pre_reg;
  logic [15:0] pre_next;
  logic        zero_next;
  wire         pre_done;
  wire         step;
  wire         at_zero;

  // Counter moves once every prescale+1 ticks
  assign pre_done = (pre_reg == tcpu_pkg::PRESCALE_ZERO);
  assign step = tick && pre_done;
  assign at_zero = (count_reg == tcpu_pkg::COUNT_ZERO);
  assign pre_next = !tick ? pre_reg :
                    pre_done ? prescale : pre_reg - tcpu_pkg::PRESCALE_ONE;
  assign count_next = !step ? count_reg :
                      at_zero ? period : count_reg - tcpu_pkg::COUNT_ONE;
  assign zero_next = step && at_zero;

  always_ff @(posedge clk) begin
    if (reset) begin
      // Reset presets the counter so the first zero comes after one period
      count_reg <= period;
      pre_reg <= tcpu_pkg::PRESCALE_RESET;
      zero_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pre_reg <= pre_next;
      zero_reg <= zero_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_reload_period: assert property (zero_reg |-> count_reg == $past(period))
    else $error("counter not reloaded from period at zero");
  a_zero_cause: assert property (zero_reg |-> $past(count_reg) == tcpu_pkg::COUNT_ZERO
                                 && $past(tick))
    else $error("zero event without counter at zero");
  a_step_only_prescaled: assert property (
      ##1 (count_reg != $past(count_reg)) |-> $past(pre_reg) == tcpu_pkg::PRESCALE_ZERO
                                              && $past(tick))
    else $error("counter moved before prescaler expired");
  a_decrement_one: assert property (step && !at_zero |=> count_reg == $past(count_reg)
                                    - tcpu_pkg::COUNT_ONE)
    else $error("counter did not decrement by one");
  a_zero_single: assert property (zero_reg && count_reg != tcpu_pkg::COUNT_ZERO
                                  |=> !zero_reg)
    else $error("zero event longer than one cycle");
endmodule : tcpu_timer_unit
`default_nettype wire

// ===== design/tcpu_timers.sv
// Three countdown timers with interrupt routing and timer 2 clock selection
`timescale 1ns/1ps
`default_nettype none
module tcpu_timers (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Timer settings
  input  wire logic [31:0] period_0,
  input  wire logic [31:0] period_1,
  input  wire logic [31:0] period_2,
  input  wire logic [15:0] prescale_0,
  input  wire logic [15:0] prescale_1,
  input  wire logic [15:0] prescale_2,
  input  wire logic        line13_enable,
  // Timer 2 clock sources and selection
  input  wire logic [1:0]  timer2_clock_select,
  input  wire logic        internal_oscillator_one,
  input  wire logic        internal_oscillator_two,
  input  wire logic        external_clock,
  // Counter values
  output var  logic [31:0] count_0,
  output var  logic [31:0] count_1,
  output var  logic [31:0] count_2,
  // Interrupt requests
  output var  logic        peripheral_interrupt_expander_req,
  output var  logic        core_irq_line_13,
  output var  logic        core_irq_line_14
);
  logic [2:0]  src_async;
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  prev_reg;
  logic [2:0]  src_rise;
  logic [2:0]  tick;
  logic [2:0]  zero;
  logic [31:0] period [3];
  logic [15:0] prescale [3];
  logic [31:0] count [3];
  logic        timer2_tick;
  logic        pie_next;
  logic        line13_next;
  logic        line14_next;

  assign src_async[tcpu_pkg::SRC_OSC_ONE] = internal_oscillator_one;
  assign src_async[tcpu_pkg::SRC_OSC_TWO] = internal_oscillator_two;
  assign src_async[tcpu_pkg::SRC_EXTERNAL] = external_clock;

  // Outside clocks pass two flops, then rising edges become ticks
  genvar s;
  generate
    for (s = 0; s < tcpu_pkg::NUM_SOURCES; s++) begin : g_sync
      always_ff @(posedge clk) begin
        if (reset) begin
          sync1_reg[s] <= 1'b0;
          sync2_reg[s] <= 1'b0;
          prev_reg[s] <= 1'b0;
        end else begin
          sync1_reg[s] <= src_async[s];
          sync2_reg[s] <= sync1_reg[s];
          prev_reg[s] <= sync2_reg[s];
        end
      end
      assign src_rise[s] = sync2_reg[s] && !prev_reg[s];
    end
  endgenerate

  // Core clock is the source for select code SEL_SYSTEM_CLOCK (0); the select input has no reset value
  assign timer2_tick =
      (timer2_clock_select == tcpu_pkg::SEL_OSC_ONE) ? src_rise[tcpu_pkg::SRC_OSC_ONE] :
      (timer2_clock_select == tcpu_pkg::SEL_OSC_TWO) ? src_rise[tcpu_pkg::SRC_OSC_TWO] :
      (timer2_clock_select == tcpu_pkg::SEL_EXTERNAL) ? src_rise[tcpu_pkg::SRC_EXTERNAL] :
      1'b1;

  assign tick[tcpu_pkg::TIMER_PIE] = 1'b1;
  assign tick[tcpu_pkg::TIMER_LINE13] = 1'b1;
  assign tick[tcpu_pkg::TIMER_LINE14] = timer2_tick;

  assign period[0] = period_0;
  assign period[1] = period_1;
  assign period[2] = period_2;
  assign prescale[0] = prescale_0;
  assign prescale[1] = prescale_1;
  assign prescale[2] = prescale_2;

  genvar t;
  generate
    for (t = 0; t < tcpu_pkg::NUM_TIMERS; t++) begin : g_timer
      tcpu_timer_unit u_timer (
        .clk       (clk),
        .reset     (reset),
        .tick      (tick[t]),
        .period    (period[t]),
        .prescale  (prescale[t]),
        .count_reg (count[t]),
        .zero_reg  (zero[t])
      );
    end
  endgenerate

  assign count_0 = count[0];
  assign count_1 = count[1];
  assign count_2 = count[2];

  // Interrupt routing
  assign pie_next = zero[tcpu_pkg::TIMER_PIE];
  assign line13_next = zero[tcpu_pkg::TIMER_LINE13] && line13_enable;
  assign line14_next = zero[tcpu_pkg::TIMER_LINE14];

  always_ff @(posedge clk) begin
    if (reset) begin
      peripheral_interrupt_expander_req <= 1'b0;
      core_irq_line_13 <= 1'b0;
      core_irq_line_14 <= 1'b0;
    end else begin
      peripheral_interrupt_expander_req <= pie_next;
      core_irq_line_13 <= line13_next;
      core_irq_line_14 <= line14_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);


  // Reset clears the requests
  a_reset_irqs: assert property (disable iff (1'b0)
      reset |=> !peripheral_interrupt_expander_req && !core_irq_line_13
                && !core_irq_line_14)
    else $error("interrupt request during reset");

  // Counters start from their period
  a_reset_counts: assert property (disable iff (1'b0)
      reset |=> count_0 == $past(period_0) && count_1 == $past(period_1)
                && count_2 == $past(period_2))
    else $error("counter not preset from period in reset");

  // Each zero event reaches its own request line; timer 1 reaches it only while line13_enable is set
  a_pie_route: assert property (
      ##1 peripheral_interrupt_expander_req == $past(zero[tcpu_pkg::TIMER_PIE]))
    else $error("expander request does not follow timer 0");

  a_line13_route: assert property (
      ##1 core_irq_line_13 == ($past(zero[tcpu_pkg::TIMER_LINE13]) && $past(line13_enable)))
    else $error("line 13 does not follow timer 1");

  a_line14_route: assert property (
      ##1 core_irq_line_14 == $past(zero[tcpu_pkg::TIMER_LINE14]))
    else $error("line 14 does not follow timer 2");

  // Line 13 stays quiet while disconnected
  a_line13_gated: assert property (
      !line13_enable |=> !core_irq_line_13)
    else $error("line 13 request while disconnected");

  // A request follows a counter that stood at zero
  a_pie_after_zero: assert property (
      peripheral_interrupt_expander_req |-> $past(count[0], 2) == tcpu_pkg::COUNT_ZERO)
    else $error("expander request without timer 0 at zero");

  a_line13_after_zero: assert property (
      core_irq_line_13 |-> $past(count[1], 2) == tcpu_pkg::COUNT_ZERO && $past(line13_enable))
    else $error("line 13 without timer 1 at zero");

  a_irq_after_zero: assert property (
      core_irq_line_14 |-> $past(count[2], 2) == tcpu_pkg::COUNT_ZERO)
    else $error("line 14 without timer 2 at zero");

  // One request per zero event unless the period is zero
  a_irq_pulse: assert property (
      peripheral_interrupt_expander_req && $past(count[0]) != tcpu_pkg::COUNT_ZERO
      |=> !peripheral_interrupt_expander_req)
    else $error("expander request longer than one cycle");

  a_irq13_pulse: assert property (
      core_irq_line_13 && $past(count[1]) != tcpu_pkg::COUNT_ZERO |=> !core_irq_line_13)
    else $error("line 13 request longer than one cycle");

  a_irq14_pulse: assert property (
      core_irq_line_14 && $past(count[2]) != tcpu_pkg::COUNT_ZERO |=> !core_irq_line_14)
    else $error("line 14 request longer than one cycle");

  // Timer 2 tick follows the selected source
  a_timer2_sysclk: assert property (
      timer2_clock_select == tcpu_pkg::SEL_SYSTEM_CLOCK |-> tick[tcpu_pkg::TIMER_LINE14])
    else $error("timer 2 not ticking on core clock");

  a_timer2_osc1: assert property (timer2_clock_select == tcpu_pkg::SEL_OSC_ONE
      |-> tick[tcpu_pkg::TIMER_LINE14] == (sync2_reg[tcpu_pkg::SRC_OSC_ONE]
          && !$past(sync2_reg[tcpu_pkg::SRC_OSC_ONE])))
    else $error("timer 2 tick not from oscillator one edge");

  a_timer2_osc2: assert property (timer2_clock_select == tcpu_pkg::SEL_OSC_TWO
      |-> tick[tcpu_pkg::TIMER_LINE14] == (sync2_reg[tcpu_pkg::SRC_OSC_TWO]
          && !$past(sync2_reg[tcpu_pkg::SRC_OSC_TWO])))
    else $error("timer 2 tick not from oscillator two edge");

  a_timer2_ext: assert property (timer2_clock_select == tcpu_pkg::SEL_EXTERNAL
      |-> tick[tcpu_pkg::TIMER_LINE14] == (sync2_reg[tcpu_pkg::SRC_EXTERNAL]
          && !$past(sync2_reg[tcpu_pkg::SRC_EXTERNAL])))
    else $error("timer 2 tick not from external edge");

  a_timer2_hold: assert property (
      timer2_clock_select != tcpu_pkg::SEL_SYSTEM_CLOCK && !tick[tcpu_pkg::TIMER_LINE14]
      |=> count_2 == $past(count_2))
    else $error("timer 2 moved without a source edge");

  // Each source passes both stages and makes single ticks
  generate
    for (s = 0; s < tcpu_pkg::NUM_SOURCES; s++) begin : g_sync_chk
      a_sync_chain: assert property (##1 sync2_reg[s] == $past(sync1_reg[s]))
        else $error("synchroniser stage skipped");
      a_tick_single: assert property (src_rise[s] |=> !src_rise[s])
        else $error("source edge longer than one cycle");
    end
  endgenerate
endmodule : tcpu_timers
`default_nettype wire

// ===== tb/tcpu_timers_tb.sv
// Self-checking bench for the triple countdown timer block
`timescale 1ns/1ps
`default_nettype none
module tcpu_timers_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] period [3];
  logic [15:0] prescale [3];
  logic        line13_enable = 1'b0;
  logic [1:0]  sel = 2'h0;
  logic [2:0]  src = 3'h0;
  logic [31:0] count [3];
  logic        irq_pie;
  logic        irq_13;
  logic        irq_14;
  logic [31:0] exp_q [$];
  logic [2:0]  irq_q [$];
  int          idx_q [$];
  int          n_errors = 0;
  int          n_tests = 0;

  always #2.5 clk = ~clk;

  tcpu_timers tcpu_timers_i (
    .clk(clk), .reset(reset),
    .period_0(period[0]), .period_1(period[1]), .period_2(period[2]),
    .prescale_0(prescale[0]), .prescale_1(prescale[1]), .prescale_2(prescale[2]),
    .line13_enable(line13_enable), .timer2_clock_select(sel),
    .internal_oscillator_one(src[0]), .internal_oscillator_two(src[1]),
    .external_clock(src[2]),
    .count_0(count[0]), .count_1(count[1]), .count_2(count[2]),
    .peripheral_interrupt_expander_req(irq_pie),
    .core_irq_line_13(irq_13), .core_irq_line_14(irq_14)
  );

  task automatic compare_count(input logic [31:0] exp, input logic [31:0] act);
    n_tests++;
    if (act !== exp) begin
      n_errors++;
      $display("unexpected count at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : compare_count

  task automatic compare_irq(input logic [2:0] exp, input logic [2:0] act);
    n_tests++;
    if (act !== exp) begin
      n_errors++;
      $display("unexpected irq at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : compare_irq

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Without a noted request every line must stay low
  always @(negedge clk) begin
    if (irq_q.size() > 0) begin
      compare_irq(irq_q.pop_front(), {irq_pie, irq_13, irq_14});
    end else begin
      compare_irq(3'h0, {irq_pie, irq_13, irq_14});
    end
    while (exp_q.size() > 0) begin
      compare_count(exp_q.pop_front(), count[idx_q.pop_front()]);
    end
  end

  task automatic do_reset();
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
  endtask : do_reset

  // First edge after release steps, then one step per prescale+1 edges
  task automatic run_prescale(input logic [15:0] p0, p1, p2, input int k);
    int n;
    prescale[0] <= p0;
    prescale[1] <= p1;
    prescale[2] <= p2;
    for (int i = 0; i < 3; i++) period[i] <= $urandom() | 32'h00010000;
    line13_enable <= 1'($urandom());
    sel <= tcpu_pkg::SEL_SYSTEM_CLOCK;
    do_reset();
    repeat (k) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      n = int'(prescale[i]);
      exp_q.push_back(period[i] - 32'((k + n) / (n + 1)));
      idx_q.push_back(i);
    end
  endtask : run_prescale

  // Pulses every source a different number of times; only the chosen one counts
  task automatic run_source(input logic [1:0] s, input int a);
    int cnt [3];
    cnt = '{a, a + 3, a + 6};
    prescale[2] <= 16'h0000;
    sel <= s;
    do_reset();
    for (int i = 0; i < 10; i++) begin
      src <= {1'(i < cnt[2]), 1'(i < cnt[1]), 1'(i < cnt[0])};
      repeat (4) @(posedge clk);
      src <= 3'h0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    exp_q.push_back(period[2] - 32'(cnt[s - 1]));
    idx_q.push_back(2);
  endtask : run_source

  // Small periods: each timer fires at a known cycle after release, then every (period+1)*(prescale+1) cycles
  task automatic run_irq(input logic en);
    logic [31:0] p [3];
    int          n [3];
    logic [2:0]  e;
    for (int i = 0; i < 3; i++) begin
      p[i] = 32'($urandom_range(0, 5));
      n[i] = $urandom_range(0, 3);
      period[i] <= p[i];
      prescale[i] <= 16'(n[i]);
    end
    line13_enable <= en;
    sel <= tcpu_pkg::SEL_SYSTEM_CLOCK;
    do_reset();
    for (int c = 1; c <= 100; c++) begin
      @(posedge clk);
      for (int i = 0; i < 3; i++) begin
        e[2 - i] = (c >= 2 + int'(p[i]) * (n[i] + 1)) &&
                   ((c - 2 - int'(p[i]) * (n[i] + 1)) % ((int'(p[i]) + 1) * (n[i] + 1)) == 0);
      end
      irq_q.push_back(e & {1'b1, en, 1'b1});
    end
    // Hold reset so no unnoted request follows the test
    reset <= 1'b1;
  endtask : run_irq

  initial begin
    logic [15:0] tbl [4];
    for (int i = 0; i < 3; i++) begin
      period[i] = 32'h00000000;
      prescale[i] = 16'h0000;
    end
    void'($urandom(42));
    tbl = '{16'h0000, 16'h0001, 16'($urandom_range(2, 7)), 16'hffff};
    @(posedge clk);
    for (int t = 0; t < 4; t++) begin
      run_prescale(tbl[t], tbl[(t + 1) % 4], tbl[(t + 2) % 4], $urandom_range(20, 60));
      $display("prescale test %0d done", t);
    end
    for (int s = 1; s < 4; s++) begin
      run_source(2'(s), $urandom_range(1, 3));
      $display("clock source test %0d done", s);
    end
    for (int i = 0; i < 2; i++) begin
      run_irq(1'(i));
      $display("interrupt test %0d done", i);
    end
    repeat (2) @(posedge clk);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : tcpu_timers_tb
`default_nettype wire
